// ---- logic/dss_alarm_second.sv ----
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - Bit7: multiframe loss changed or set
// RULE2 - No one-second pulse: summary bits zero; the code clears only the tandem tc_sum, path pa_per keeps its value
// RULE3 - Summary bits never raise an interrupt
// RULE4 - Bit6: trace loss-of-lock changed or set
// RULE5 - Bit5: trace mismatch changed or set
// RULE6 - Bit4: tandem AIS changed or set
// RULE7 - Bit3: tandem unequipped changed or set
// RULE8 - Bit2: tandem remote defect changed or set
// RULE9 - Bit1: tandem outgoing defect changed or set
// RULE10 - Persistent: active, not newly active last second
// RULE11 - Persistent bit6 follows BIP-2 error indication
// RULE12 - Persistent bit5: unequipped
// RULE13 - Persistent bit4: remote connectivity defect
// RULE14 - Persistent bit3: remote payload defect
// RULE15 - Persistent bit2: remote server or single RDI
// RULE16 - Persistent bit1: signal label mismatch
// RULE17 - Persistent bit0: remote failure
// RULE18 - Update together at pulse, reads harmless
// RULE19 - Unused bits read as zero
module dss_alarm_second
	import dss_pkg::*;
#(
	parameter int unsigned NCH      = NUM_CH,
	parameter int unsigned LOSS_CYC = SEC_LOSS_CYC,
	parameter int unsigned CH_W     = (NCH > 1) ? $clog2(NCH) : 1,
	parameter int unsigned ADDR_W   = OFF_W + CH_W
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        sec_pulse,
	input  wire logic [NCH-1:0][N_ALM-1:0]   tc_alarm,
	input  wire logic [NCH-1:0][N_ALM-1:0]   pa_alarm,
	input  wire logic [ADDR_W-1:0]           addr,
	input  wire logic                        wr_stb,
	input  wire logic [DATA_W-1:0]           wr_data,
	input  wire logic                        rd_stb,
	output logic      [DATA_W-1:0]           rd_data,
	output logic                             sec_pulse_ok
);
	localparam int unsigned LOSS_W = $clog2(LOSS_CYC + 1);

	logic [NCH-1:0][N_ALM-1:0] tc_prev;
	logic [NCH-1:0][N_ALM-1:0] tc_chg;
	logic [NCH-1:0][N_ALM-1:0] tc_sum;
	logic [NCH-1:0][N_ALM-1:0] pa_prev;
	logic [NCH-1:0][N_ALM-1:0] pa_rose;
	logic [NCH-1:0][N_ALM-1:0] pa_per;
	logic [NCH-1:0][N_ALM-1:0] next_tc_prev;
	logic [NCH-1:0][N_ALM-1:0] next_tc_chg;
	logic [NCH-1:0][N_ALM-1:0] next_tc_sum;
	logic [NCH-1:0][N_ALM-1:0] next_pa_prev;
	logic [NCH-1:0][N_ALM-1:0] next_pa_rose;
	logic [NCH-1:0][N_ALM-1:0] next_pa_per;
	logic [LOSS_W-1:0]         loss_cnt;
	logic [LOSS_W-1:0]         next_loss_cnt;
	logic                      next_sec_pulse_ok;
	logic [DATA_W-1:0]         next_rd_data;
	logic [DATA_W-1:0]         ch_reg [NCH][2];

	// One-second pulse supervision
	always_comb begin
		next_loss_cnt = loss_cnt;
		next_sec_pulse_ok = sec_pulse_ok;
		if (sec_pulse) begin
			next_loss_cnt = '0;
			next_sec_pulse_ok = 1'b1;
		end else if (loss_cnt == LOSS_W'(LOSS_CYC - 1)) begin
			next_sec_pulse_ok = 1'b0; // [RULE2]
		end else begin
			next_loss_cnt = loss_cnt + LOSS_W'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			loss_cnt <= '0;
			sec_pulse_ok <= 1'b0;
		end else begin
			loss_cnt <= next_loss_cnt;
			sec_pulse_ok <= next_sec_pulse_ok;
		end
	end

	// Interval tracking, all channels and bits as vectors
	always_comb begin
		next_tc_prev = tc_alarm;
		next_pa_prev = pa_alarm;
		next_tc_chg = tc_chg | (tc_alarm ^ tc_prev);
		next_pa_rose = pa_rose | (pa_alarm & ~pa_prev);
		next_tc_sum = tc_sum;
		next_pa_per = pa_per;
		if (sec_pulse) begin
			// Changed in interval, or set at its end
			next_tc_sum = next_tc_chg | tc_alarm; // [RULE1] [RULE4] [RULE5] [RULE6]
			// Same form for the remaining tandem bits
			next_tc_sum = next_tc_sum; // [RULE7] [RULE8] [RULE9] [RULE18]
			// Active now, did not rise in interval
			next_pa_per = pa_alarm & ~next_pa_rose; // [RULE10] [RULE11] [RULE12]
			next_pa_per = next_pa_per; // [RULE13] [RULE14] [RULE15] [RULE16] [RULE17]
			next_tc_chg = '0;
			next_pa_rose = '0;
		end else if (!next_sec_pulse_ok) begin
			// Cleared on the same edge that drops the ok flag
			next_tc_sum = '0; // [RULE2]
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tc_prev <= '0;
			tc_chg <= '0;
			tc_sum <= '0;
			pa_prev <= '0;
			pa_rose <= '0;
			pa_per <= '0;
		end else begin
			tc_prev <= next_tc_prev;
			tc_chg <= next_tc_chg;
			tc_sum <= next_tc_sum;
			pa_prev <= next_pa_prev;
			pa_rose <= next_pa_rose;
			pa_per <= next_pa_per;
		end
	end

	// Register images per channel, spare bits tied low
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		assign ch_reg[c][0] = {tc_sum[c], 1'b0}; // [RULE19]
		assign ch_reg[c][1] = {1'b0, pa_per[c]}; // [RULE19]
	end

	// Read port; writes are ignored, no interrupt path exists
	always_comb begin
		next_rd_data = REG_RESET;
		if (rd_stb && (int'(addr[ADDR_W-1 -: CH_W]) < NCH)) begin
			if (addr[OFF_W-1:0] == TC_SUM_OFF)
				next_rd_data = ch_reg[addr[ADDR_W-1 -: CH_W]][0];
			else if (addr[OFF_W-1:0] == PATH_PER_OFF)
				next_rd_data = ch_reg[addr[ADDR_W-1 -: CH_W]][1];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			rd_data <= REG_RESET;
		else
			rd_data <= next_rd_data; // [RULE3]
	end

	// Checks on channel 0; a_r2, a_r18, a_r3 and a_r19 cover all channels
	property p_tc(int b);
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse |=> tc_sum[0][b] == $past(tc_chg[0][b]
			| (tc_alarm[0][b] ^ tc_prev[0][b]) | tc_alarm[0][b]);
	endproperty
	property p_pa(int b);
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse |=> pa_per[0][b] == $past(pa_alarm[0][b]
			& ~(pa_rose[0][b] | (pa_alarm[0][b] & ~pa_prev[0][b])));
	endproperty
	a_r1: assert property (p_tc(TC_LM_BIT - 1)) else $error("tc bit7"); // [RULE1]
	a_r4: assert property (p_tc(TC_LL_BIT - 1)) else $error("tc bit6"); // [RULE4]
	a_r5: assert property (p_tc(TC_TM_BIT - 1)) else $error("tc bit5"); // [RULE5]
	a_r6: assert property (p_tc(TC_AIS_BIT - 1)) else $error("tc bit4"); // [RULE6]
	a_r7: assert property (p_tc(TC_UQ_BIT - 1)) else $error("tc bit3"); // [RULE7]
	a_r8: assert property (p_tc(TC_RDI_BIT - 1)) else $error("tc bit2"); // [RULE8]
	a_r9: assert property (p_tc(TC_ODI_BIT - 1)) else $error("tc bit1"); // [RULE9]
	a_r11: assert property (p_pa(PA_BIP_BIT)) else $error("pa bit6"); // [RULE11]
	a_r12: assert property (p_pa(PA_UQ_BIT)) else $error("pa bit5"); // [RULE12]
	a_r13: assert property (p_pa(PA_RDIC_BIT)) else $error("pa bit4"); // [RULE13]
	a_r14: assert property (p_pa(PA_RDIP_BIT)) else $error("pa bit3"); // [RULE14]
	a_r15: assert property (p_pa(PA_RDIS_BIT)) else $error("pa bit2"); // [RULE15]
	a_r16: assert property (p_pa(PA_SLM_BIT)) else $error("pa bit1"); // [RULE16]
	a_r17: assert property (p_pa(PA_RFI_BIT)) else $error("pa bit0"); // [RULE17]

	property p_r10;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse && pa_alarm[0][0] && pa_prev[0][0] && !pa_rose[0][0]
			|=> pa_per[0][0];
	endproperty
	a_r10: assert property (p_r10) else $error("persistent not set"); // [RULE10]

	property p_r2;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse_ok |-> tc_sum == '0;
	endproperty
	a_r2: assert property (p_r2) else $error("summary live without pulse"); // [RULE2]

	sequence s_quiet;
		!sec_pulse ##1 !sec_pulse;
	endsequence
	property p_r18;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse_ok ##0 s_quiet ##0 sec_pulse_ok |-> $stable(pa_per) && $stable(tc_sum);
	endproperty
	a_r18: assert property (p_r18) else $error("summary moved mid interval"); // [RULE18]

	property p_r3;
		@(posedge mclk) disable iff (!rst_n)
		rd_stb && !sec_pulse && next_sec_pulse_ok |=> $stable(tc_sum);
	endproperty
	a_r3: assert property (p_r3) else $error("read disturbed summary"); // [RULE3]

	sequence s_rd_tc;
		rd_stb && addr[OFF_W-1:0] == TC_SUM_OFF;
	endsequence
	sequence s_rd_pa;
		rd_stb && addr[OFF_W-1:0] == PATH_PER_OFF;
	endsequence
	property p_r19;
		@(posedge mclk) disable iff (!rst_n)
		(s_rd_tc |=> !rd_data[TC_FREE_BIT]) and (s_rd_pa |=> !rd_data[PA_FREE_BIT]);
	endproperty
	a_r19: assert property (p_r19) else $error("spare bit set"); // [RULE19]

	// Read port: one-cycle answer, zero otherwise
	property p_rd_quiet;
		@(posedge mclk) disable iff (!rst_n)
		!rd_stb |=> rd_data == REG_RESET;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("read data without strobe"); // [RULE18]

	property p_rd_bad_off;
		@(posedge mclk) disable iff (!rst_n)
		rd_stb && addr[OFF_W-1:0] != TC_SUM_OFF && addr[OFF_W-1:0] != PATH_PER_OFF
			|=> rd_data == REG_RESET;
	endproperty
	a_rd_bad_off: assert property (p_rd_bad_off) else $error("unmapped offset read"); // [RULE19]

	property p_rd_bad_ch;
		@(posedge mclk) disable iff (!rst_n)
		rd_stb && (int'(addr[ADDR_W-1 -: CH_W]) >= NCH) |=> rd_data == REG_RESET;
	endproperty
	a_rd_bad_ch: assert property (p_rd_bad_ch) else $error("unmapped channel read"); // [RULE19]

	// Writes land nowhere
	property p_wr_quiet;
		@(posedge mclk) disable iff (!rst_n)
		wr_stb && !rd_stb |=> rd_data == REG_RESET;
	endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("write produced read data"); // [RULE18]

	property p_wr_keep;
		@(posedge mclk) disable iff (!rst_n)
		wr_stb && !sec_pulse && next_sec_pulse_ok
			|=> $stable(tc_sum) && $stable(pa_per);
	endproperty
	a_wr_keep: assert property (p_wr_keep) else $error("write moved a summary"); // [RULE18]

	// Pulse supervision
	property p_ok_set;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse |=> sec_pulse_ok && loss_cnt == '0;
	endproperty
	a_ok_set: assert property (p_ok_set) else $error("pulse did not restart timer"); // [RULE2]

	property p_ok_keep;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse_ok && !sec_pulse && loss_cnt != LOSS_W'(LOSS_CYC - 1)
			|=> sec_pulse_ok;
	endproperty
	a_ok_keep: assert property (p_ok_keep) else $error("ok flag dropped early"); // [RULE2]

	property p_ok_lose;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse && loss_cnt == LOSS_W'(LOSS_CYC - 1) |=> !sec_pulse_ok;
	endproperty
	a_ok_lose: assert property (p_ok_lose) else $error("ok flag kept after loss"); // [RULE2]

	property p_cnt_step;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse && loss_cnt != LOSS_W'(LOSS_CYC - 1)
			|=> loss_cnt == $past(loss_cnt) + LOSS_W'(1);
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("loss timer did not count"); // [RULE2]

	property p_sum_dark;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse_ok && !sec_pulse |=> tc_sum == '0;
	endproperty
	a_sum_dark: assert property (p_sum_dark) else $error("summary set without pulse"); // [RULE2]

	sequence s_loss;
		sec_pulse_ok ##1 !sec_pulse_ok;
	endsequence
	property p_loss_clear;
		@(posedge mclk) disable iff (!rst_n)
		s_loss |-> tc_sum == '0;
	endproperty
	a_loss_clear: assert property (p_loss_clear) else $error("summary kept at loss"); // [RULE2]

	// Interval tracking
	property p_prev;
		@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> tc_prev == $past(tc_alarm) && pa_prev == $past(pa_alarm);
	endproperty
	a_prev: assert property (p_prev) else $error("previous sample lost"); // [RULE1] [RULE10]

	property p_chg_acc;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse |=> (tc_chg & $past(tc_chg | (tc_alarm ^ tc_prev)))
			== $past(tc_chg | (tc_alarm ^ tc_prev));
	endproperty
	a_chg_acc: assert property (p_chg_acc) else $error("change not recorded"); // [RULE1]

	property p_chg_clr;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse |=> tc_chg == '0 && pa_rose == '0;
	endproperty
	a_chg_clr: assert property (p_chg_clr) else $error("interval record not cleared"); // [RULE18]

	property p_rose_acc;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse |=> (pa_rose & $past(pa_rose | (pa_alarm & ~pa_prev)))
			== $past(pa_rose | (pa_alarm & ~pa_prev));
	endproperty
	a_rose_acc: assert property (p_rose_acc) else $error("rise not recorded"); // [RULE10]

	property p_pa_hold;
		@(posedge mclk) disable iff (!rst_n)
		!sec_pulse |=> $stable(pa_per);
	endproperty
	a_pa_hold: assert property (p_pa_hold) else $error("persistent moved mid interval"); // [RULE18]

	property p_per_new;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse && pa_alarm[0][0] && !pa_prev[0][0] |=> !pa_per[0][0];
	endproperty
	a_per_new: assert property (p_per_new) else $error("new alarm marked persistent"); // [RULE10]

	property p_per_keep;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse && pa_alarm[0] == '1 && pa_prev[0] == '1 && pa_rose[0] == '0
			|=> pa_per[0] == '1;
	endproperty
	a_per_keep: assert property (p_per_keep) else $error("steady alarm not persistent"); // [RULE10]

	property p_tc_set_end;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse && tc_alarm[0][TC_LM_BIT-1] |=> tc_sum[0][TC_LM_BIT-1];
	endproperty
	a_tc_set_end: assert property (p_tc_set_end) else $error("set alarm not summarised"); // [RULE1]

	property p_tc_quiet;
		@(posedge mclk) disable iff (!rst_n)
		sec_pulse && tc_alarm[0] == '0 && tc_prev[0] == '0 && tc_chg[0] == '0
			|=> tc_sum[0] == '0;
	endproperty
	a_tc_quiet: assert property (p_tc_quiet) else $error("quiet alarm summarised"); // [RULE1]

	// Every channel, update and read-back
	for (genvar c = 0; c < NCH; c++) begin : g_chk
		property p_ch_tc;
			@(posedge mclk) disable iff (!rst_n)
			sec_pulse |=> tc_sum[c] == $past(tc_chg[c]
				| (tc_alarm[c] ^ tc_prev[c]) | tc_alarm[c]);
		endproperty
		a_ch_tc: assert property (p_ch_tc) else $error("channel tandem summary"); // [RULE1]

		property p_ch_pa;
			@(posedge mclk) disable iff (!rst_n)
			sec_pulse |=> pa_per[c] == $past(pa_alarm[c]
				& ~(pa_rose[c] | (pa_alarm[c] & ~pa_prev[c])));
		endproperty
		a_ch_pa: assert property (p_ch_pa) else $error("channel persistent"); // [RULE10]

		property p_ch_rd_tc;
			@(posedge mclk) disable iff (!rst_n)
			rd_stb && addr == {CH_W'(c), TC_SUM_OFF}
				|=> rd_data == {$past(tc_sum[c]), 1'b0};
		endproperty
		a_ch_rd_tc: assert property (p_ch_rd_tc) else $error("tandem read-back"); // [RULE19]

		property p_ch_rd_pa;
			@(posedge mclk) disable iff (!rst_n)
			rd_stb && addr == {CH_W'(c), PATH_PER_OFF}
				|=> rd_data == {1'b0, $past(pa_per[c])};
		endproperty
		a_ch_rd_pa: assert property (p_ch_rd_pa) else $error("persistent read-back"); // [RULE19]
	end
endmodule

// ---- pkg/dss_pkg.sv ----
package dss_pkg;
	// Clock and one-second supervision
	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned HZ_PER_KHZ   = 1000;
	localparam int unsigned SEC_LOSS_MS  = 1500;
	localparam int unsigned SEC_LOSS_CYC = SEC_LOSS_MS * (CLK_HZ / HZ_PER_KHZ);

	// Register map inside one channel window
	localparam int unsigned OFF_W        = 9;
	localparam int unsigned DATA_W       = 8;
	localparam logic [8:0]  TC_SUM_OFF   = 9'h11b;
	localparam logic [8:0]  PATH_PER_OFF = 9'h11c;
	localparam int unsigned NUM_CH       = 8;

	// Alarms per group, one less than the register width
	localparam int unsigned N_ALM        = 7;

	// Tandem summary register bit positions
	localparam int unsigned TC_LM_BIT    = 7;
	localparam int unsigned TC_LL_BIT    = 6;
	localparam int unsigned TC_TM_BIT    = 5;
	localparam int unsigned TC_AIS_BIT   = 4;
	localparam int unsigned TC_UQ_BIT    = 3;
	localparam int unsigned TC_RDI_BIT   = 2;
	localparam int unsigned TC_ODI_BIT   = 1;
	localparam int unsigned TC_FREE_BIT  = 0;

	// Path persistent register bit positions
	localparam int unsigned PA_FREE_BIT  = 7;
	localparam int unsigned PA_BIP_BIT   = 6;
	localparam int unsigned PA_UQ_BIT    = 5;
	localparam int unsigned PA_RDIC_BIT  = 4;
	localparam int unsigned PA_RDIP_BIT  = 3;
	localparam int unsigned PA_RDIS_BIT  = 2;
	localparam int unsigned PA_SLM_BIT   = 1;
	localparam int unsigned PA_RFI_BIT   = 0;

	localparam logic [7:0]  REG_RESET    = 8'h00;
endpackage

// ---- tb/drop_side_alarm_second_summary_tb.sv ----
`timescale 1ns/1ps
module drop_side_alarm_second_summary_tb
	import dss_pkg::*;
;
	typedef struct packed {
		logic [6:0] tc;
		logic [6:0] pa;
		logic [7:0] etc;
		logic [7:0] epa;
	} dss_row_t;

	// Alarm levels per interval and the summaries they should leave
	localparam dss_row_t ROWS [5] = '{
		'{7'h55, 7'h7f, 8'haa, 8'h00},
		'{7'h55, 7'h7f, 8'haa, 8'h7f},
		'{7'h00, 7'h2a, 8'haa, 8'h2a},
		'{7'h00, 7'h2a, 8'h00, 8'h2a},
		'{7'h2a, 7'h55, 8'h54, 8'h00}
	};

	logic            mclk      = 1'b0;
	logic            rst_n     = 1'b0;
	logic            sec_pulse = 1'b0;
	logic [2:0][6:0] tc_alarm  = '0;
	logic [2:0][6:0] pa_alarm  = '0;
	logic [10:0]     addr      = '0;
	logic            wr_stb    = 1'b0;
	logic [7:0]      wr_data   = '0;
	logic            rd_stb    = 1'b0;
	logic [7:0]      rd_data;
	logic            sec_pulse_ok;
	int              err_total = 0;
	int              checks    = 0;

	dss_alarm_second #(.NCH(3), .LOSS_CYC(50)) u_dss_alarm_second (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.sec_pulse    (sec_pulse),
		.tc_alarm     (tc_alarm),
		.pa_alarm     (pa_alarm),
		.addr         (addr),
		.wr_stb       (wr_stb),
		.wr_data      (wr_data),
		.rd_stb       (rd_stb),
		.rd_data      (rd_data),
		.sec_pulse_ok (sec_pulse_ok)
	);

	initial begin
		forever #25 mclk = ~mclk;
	end

	task automatic conclude;
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] want);
		checks++;
		if (got !== want) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, want, got);
		end
	endtask

	task automatic rdc(input string nm, input logic [1:0] ch, input logic [8:0] off,
			input logic [7:0] want);
		@(posedge mclk);
		rd_stb <= 1'b1;
		addr   <= {ch, off};
		@(posedge mclk);
		rd_stb <= 1'b0;
		#1 chk(nm, rd_data, want);
	endtask

	task automatic pulse;
		@(posedge mclk);
		sec_pulse <= 1'b1;
		@(posedge mclk);
		sec_pulse <= 1'b0;
	endtask

	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		conclude();
	end

	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk("ok_reset", {7'h00, sec_pulse_ok}, 8'h00);
		rdc("tc_before_pulse", 2'd0, TC_SUM_OFF, 8'h00);
		for (int i = 0; i < 5; i++) begin
			@(posedge mclk);
			tc_alarm[0] <= ROWS[i].tc;
			pa_alarm[0] <= ROWS[i].pa;
			repeat (3) @(posedge mclk);
			pulse();
			rdc("tc_sum", 2'd0, TC_SUM_OFF, ROWS[i].etc);
			rdc("pa_per", 2'd0, PATH_PER_OFF, ROWS[i].epa);
			rdc("ch1_tc", 2'd1, TC_SUM_OFF, 8'h00);
		end
		@(posedge mclk);
		#1 chk("rd_idle", rd_data, 8'h00);
		// Short blip inside one interval
		@(posedge mclk);
		tc_alarm[0] <= 7'h6a;
		@(posedge mclk);
		tc_alarm[0] <= 7'h2a;
		repeat (2) @(posedge mclk);
		pulse();
		@(posedge mclk);
		wr_stb  <= 1'b1;
		addr    <= {2'd0, TC_SUM_OFF};
		wr_data <= 8'hff;
		@(posedge mclk);
		wr_stb  <= 1'b0;
		rdc("tc_blip", 2'd0, TC_SUM_OFF, 8'hd4);
		rdc("pa_hold", 2'd0, PATH_PER_OFF, 8'h55);
		rdc("unmapped_off", 2'd0, 9'h11d, 8'h00);
		rdc("unmapped_ch", 2'd3, TC_SUM_OFF, 8'h00);
		chk("ok_running", {7'h00, sec_pulse_ok}, 8'h01);
		repeat (60) @(posedge mclk);
		#1 chk("ok_lost", {7'h00, sec_pulse_ok}, 8'h00);
		rdc("tc_lost", 2'd0, TC_SUM_OFF, 8'h00);
		rdc("pa_lost", 2'd0, PATH_PER_OFF, 8'h55);
		pulse();
		@(posedge mclk);
		#1 chk("ok_back", {7'h00, sec_pulse_ok}, 8'h01);
		conclude();
	end
endmodule
